// *** rtl/csp_fifo.sv ***
/*
 Word FIFO with valid and ready on both sides.
 Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module csp_fifo
    import csp_pkg::*;
#(
    parameter int WIDTH = WORD_BITS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } csp_fifo_state_type;

    csp_fifo_state_type state_reg;
    csp_fifo_state_type state_next;
    logic               full;
    logic               empty;

    // Pointers carry one extra wrap bit
    assign empty     = state_reg.wr_ptr == state_reg.rd_ptr;
    assign full      = (state_reg.wr_ptr[AW-1:0] == state_reg.rd_ptr[AW-1:0])
                       && (state_reg.wr_ptr[AW] != state_reg.rd_ptr[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = state_reg.mem[state_reg.rd_ptr[AW-1:0]];

    always_comb begin
        state_next = state_reg;
        if (in_valid && !full) begin
            state_next.mem[state_reg.wr_ptr[AW-1:0]] = in_data;
            state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
        end
        if (out_ready && !empty) begin
            state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : csp_fifo

// *** rtl/csp_pkg.sv ***
/*
 Shared constants and carrier types of the codec serial port.
 Assumes one system clock that stands in for the external master clock.
*/
package csp_pkg;

    localparam int WORD_BITS     = 16;
    localparam int CTRL_COUNT    = 5;
    localparam int CTRL_BITS     = 8;
    localparam int SAMPLE_DIV    = 256;
    localparam int SYNC_STAGES   = 3;
    localparam int CTRL_FLAG_BIT = 15;
    localparam int READ_FLAG_BIT = 14;
    localparam int SEL_LSB       = 8;
    localparam int SEL_BITS      = 3;
    localparam int CNT_BITS      = 8;
    localparam int BIT_CNT_BITS  = 5;
    localparam int FIFO_DEPTH    = 16;

    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 8'h00;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
    localparam logic [2:0]           READ_PAD   = 3'h0;

    typedef logic [CTRL_COUNT-1:0][CTRL_BITS-1:0] csp_ctrl_file_type;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_FRAME,
        TX_BITS
    } csp_tx_state_type;

    typedef enum logic {
        RX_IDLE,
        RX_RECV
    } csp_rx_state_type;

    // Pins toward the host, each with its enable
    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic codec_tx_line;
        logic codec_tx_line_oe;
        logic tx_frame_pulse;
        logic tx_frame_pulse_oe;
    } csp_pin_out_type;

    // Pins from the host
    typedef struct packed {
        logic port_enable_pin;
        logic codec_rx_line;
        logic rx_frame_pulse;
    } csp_pin_in_type;

endpackage : csp_pkg

// *** rtl/csp_port.sv ***
/*
 Serial port of a voiceband codec: clock dividers, frame and word timing,
 control registers, sample update, port enable. Assumes clk_sys is the
 external master clock and the host follows the frame timing below.
*/
`timescale 1ns/1ps
module csp_port
    import csp_pkg::*;
#(
    parameter int MCLK_DIV = 2,
    parameter int SCLK_DIV = 4
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire csp_pin_in_type          pins_in,
    output csp_pin_out_type              pins_out,
    input  wire logic [WORD_BITS-1:0]    adc_data,
    input  wire logic                    adc_valid,
    output logic                         adc_ready,
    output logic      [WORD_BITS-1:0]    dac_sample,
    output csp_ctrl_file_type            ctrl_regs
);
    localparam int SCLK_HALF = (MCLK_DIV * SCLK_DIV) / 2;
    localparam int FS_CYCLES = MCLK_DIV * SCLK_DIV;
    localparam logic [CNT_BITS-1:0] DIV_LAST  = CNT_BITS'(MCLK_DIV - 1);
    localparam logic [CNT_BITS-1:0] HALF_LAST = CNT_BITS'(SCLK_HALF - 1);
    localparam logic [CNT_BITS-1:0] DM_LAST   = CNT_BITS'(SAMPLE_DIV - 1);
    localparam logic [BIT_CNT_BITS-1:0] BITS_LAST =
        BIT_CNT_BITS'(WORD_BITS - 1);
    localparam logic [BIT_CNT_BITS-1:0] BITS_ALL = BIT_CNT_BITS'(WORD_BITS);

    typedef struct packed {
        logic [SYNC_STAGES-1:0]  en_sync;
        logic [SYNC_STAGES-1:0]  fs_sync;
        logic [SYNC_STAGES-1:0]  dat_sync;
        logic                    en;
        logic                    fs_in;
        logic                    dat_in;
        logic [CNT_BITS-1:0]     div_cnt;
        logic [CNT_BITS-1:0]     sclk_cnt;
        logic [CNT_BITS-1:0]     dm_cnt;
        logic                    sclk;
        csp_tx_state_type        tx_state;
        logic [BIT_CNT_BITS-1:0] tx_cnt;
        logic [WORD_BITS-1:0]    tx_shift;
        logic [WORD_BITS-1:0]    tx_word;
        logic                    tx_pend;
        logic                    fs_out;
        logic                    tx_oe;
        logic                    tx_bit;
        csp_rx_state_type        rx_state;
        logic [BIT_CNT_BITS-1:0] rx_cnt;
        logic [WORD_BITS-1:0]    rx_shift;
        logic [WORD_BITS-1:0]    dac_latest;
        logic [WORD_BITS-1:0]    dac_out;
        logic [WORD_BITS-1:0]    adc_last;
        logic                    rd_pend;
        logic [SEL_BITS-1:0]     rd_sel;
        csp_ctrl_file_type       ctrl;
    } csp_state_type;

    csp_state_type        state_reg;
    csp_state_type        state_next;
    logic                 dm_en;
    logic                 tick;
    logic                 rise;
    logic                 fall;
    logic                 fifo_valid;
    logic [WORD_BITS-1:0] fifo_data;
    logic                 fifo_pop;

    csp_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (adc_data),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign dm_en = state_reg.en && (state_reg.div_cnt == DIV_LAST);
    assign tick  = dm_en && (state_reg.dm_cnt == DM_LAST);
    assign rise  = state_reg.en && (state_reg.sclk_cnt == HALF_LAST)
                   && !state_reg.sclk;
    assign fall  = state_reg.en && (state_reg.sclk_cnt == HALF_LAST)
                   && state_reg.sclk;
    assign fifo_pop = tick && !state_reg.rd_pend;

    always_comb begin
        logic [WORD_BITS-1:0] word;
        logic [SEL_BITS-1:0]  sel;
        word = WORD_RESET;
        sel  = '0;
        state_next = state_reg;
        // Three-stage synchronisers, change taken when the last two stages agree
        state_next.en_sync  = {state_reg.en_sync[1:0],
                               pins_in.port_enable_pin};
        state_next.fs_sync  = {state_reg.fs_sync[1:0],
                               pins_in.rx_frame_pulse};
        state_next.dat_sync = {state_reg.dat_sync[1:0],
                               pins_in.codec_rx_line};
        if (state_reg.en_sync[1] == state_reg.en_sync[2]) begin
            state_next.en = state_reg.en_sync[2];
        end
        if (state_reg.fs_sync[1] == state_reg.fs_sync[2]) begin
            state_next.fs_in = state_reg.fs_sync[2];
        end
        if (state_reg.dat_sync[1] == state_reg.dat_sync[2]) begin
            state_next.dat_in = state_reg.dat_sync[2];
        end

        if (!state_reg.en) begin
            // Timing restarts, registers and samples kept
            state_next.div_cnt  = '0;
            state_next.sclk_cnt = '0;
            state_next.dm_cnt   = '0;
            state_next.sclk     = 1'b0;
            state_next.tx_state = TX_IDLE;
            state_next.tx_cnt   = '0;
            state_next.tx_pend  = 1'b0;
            state_next.fs_out   = 1'b0;
            state_next.tx_oe    = 1'b0;
            state_next.tx_bit   = 1'b0;
            state_next.rx_state = RX_IDLE;
            state_next.rx_cnt   = '0;
        end else begin
            state_next.div_cnt = dm_en ? '0 : state_reg.div_cnt + 1'b1;
            if (dm_en) begin
                state_next.dm_cnt = state_reg.dm_cnt + 1'b1;
            end
            if (state_reg.sclk_cnt == HALF_LAST) begin
                state_next.sclk_cnt = '0;
                state_next.sclk     = !state_reg.sclk;
            end else begin
                state_next.sclk_cnt = state_reg.sclk_cnt + 1'b1;
            end

            // Sample exchange
            if (tick) begin
                state_next.dac_out = state_reg.dac_latest;
                state_next.tx_pend = 1'b1;
                if (state_reg.rd_pend) begin
                    state_next.rd_pend = 1'b0;
                    state_next.tx_word = {1'b1, 1'b1, READ_PAD,
                        state_reg.rd_sel, state_reg.ctrl[state_reg.rd_sel]};
                end else if (fifo_valid) begin
                    state_next.tx_word  = fifo_data;
                    state_next.adc_last = fifo_data;
                end else begin
                    state_next.tx_word = state_reg.adc_last;
                end
            end

            if (rise) begin
                case (state_reg.tx_state)
                    TX_IDLE: begin
                        if (state_reg.tx_pend) begin
                            state_next.fs_out   = 1'b1;
                            state_next.tx_pend  = 1'b0;
                            state_next.tx_state = TX_FRAME;
                        end
                    end
                    TX_FRAME: begin
                        state_next.fs_out   = 1'b0;
                        state_next.tx_oe    = 1'b1;
                        state_next.tx_bit   =
                            state_reg.tx_word[WORD_BITS-1];
                        state_next.tx_shift = {state_reg.tx_word[WORD_BITS-2:0],
                                               1'b0};
                        state_next.tx_cnt   = BIT_CNT_BITS'(1);
                        state_next.tx_state = TX_BITS;
                    end
                    TX_BITS: begin
                        if (state_reg.tx_cnt == BITS_ALL) begin
                            state_next.tx_oe    = 1'b0;
                            state_next.tx_state = TX_IDLE;
                        end else begin
                            state_next.tx_bit   =
                                state_reg.tx_shift[WORD_BITS-1];
                            state_next.tx_shift =
                                {state_reg.tx_shift[WORD_BITS-2:0], 1'b0};
                            state_next.tx_cnt   = state_reg.tx_cnt + 1'b1;
                        end
                    end
                    default: begin
                        state_next.tx_state = TX_IDLE;
                    end
                endcase
            end

            if (fall) begin
                case (state_reg.rx_state)
                    RX_IDLE: begin
                        if (state_reg.fs_in) begin
                            state_next.rx_state = RX_RECV;
                            state_next.rx_cnt   = '0;
                        end
                    end
                    RX_RECV: begin
                        word = {state_reg.rx_shift[WORD_BITS-2:0],
                                state_reg.dat_in};
                        state_next.rx_shift = word;
                        state_next.rx_cnt   = state_reg.rx_cnt + 1'b1;
                        if (state_reg.rx_cnt == BITS_LAST) begin
                            state_next.rx_state = RX_IDLE;
                            sel = word[SEL_LSB +: SEL_BITS];
                            if (!word[CTRL_FLAG_BIT]) begin
                                state_next.dac_latest = word;
                            end else if (sel < SEL_BITS'(CTRL_COUNT)) begin
                                if (word[READ_FLAG_BIT]) begin
                                    state_next.rd_pend = 1'b1;
                                    state_next.rd_sel  = sel;
                                end else begin
                                    state_next.ctrl[sel] =
                                        word[CTRL_BITS-1:0];
                                end
                            end
                        end
                    end
                    default: begin
                        state_next.rx_state = RX_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg          <= '0;
            state_reg.ctrl     <= {CTRL_COUNT{CTRL_RESET}};
            state_reg.tx_state <= TX_IDLE;
            state_reg.rx_state <= RX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pins_out.sclk              = state_reg.sclk;
    assign pins_out.sclk_oe           = state_reg.en;
    assign pins_out.codec_tx_line     = state_reg.tx_bit;
    assign pins_out.codec_tx_line_oe  = state_reg.tx_oe && state_reg.en;
    assign pins_out.tx_frame_pulse    = state_reg.fs_out;
    assign pins_out.tx_frame_pulse_oe = state_reg.en;
    assign dac_sample                 = state_reg.dac_out;
    assign ctrl_regs                  = state_reg.ctrl;

    sequence seq_frame_pulse;
        $rose(state_reg.fs_out);
    endsequence

    sequence seq_first_bit;
        $rose(state_reg.tx_oe) && !state_reg.fs_out;
    endsequence

    chk_reset_clear: assert property (@(posedge clk_sys)
        !rst_n |=> state_reg.ctrl == {CTRL_COUNT{CTRL_RESET}}
        && !state_reg.tx_oe)
        else $error("reset left state");
    chk_sclk_rate: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        state_reg.en && $past(state_reg.en) && $changed(state_reg.sclk)
        |-> $past(state_reg.sclk_cnt) == HALF_LAST)
        else $error("serial clock off rate");
    chk_msb_first: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        seq_first_bit |-> state_reg.tx_bit == state_reg.tx_word[WORD_BITS-1])
        else $error("first bit not msb");
    chk_tx_float: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        !state_reg.en |-> !pins_out.codec_tx_line_oe
        && !pins_out.tx_frame_pulse_oe && !pins_out.sclk_oe)
        else $error("outputs driven while disabled");
    chk_frame_width: assert property (@(posedge clk_sys)
        disable iff (!rst_n || !state_reg.en)
        seq_frame_pulse |-> ##FS_CYCLES seq_first_bit)
        else $error("frame pulse not before msb");
    chk_frame_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_n || !state_reg.en)
        $fell(state_reg.fs_out) |-> $past(state_reg.fs_out, FS_CYCLES))
        else $error("frame pulse not one period");
    chk_rx_start: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        fall && state_reg.rx_state == RX_IDLE && state_reg.fs_in
        |=> state_reg.rx_state == RX_RECV)
        else $error("input frame missed");
    chk_regs_kept: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        $rose(state_reg.en) |-> $stable(state_reg.ctrl)
        && state_reg.dm_cnt == '0)
        else $error("re-enable lost registers");
    chk_sample_tick: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        tick |=> state_reg.dac_out == $past(state_reg.dac_latest)
        && state_reg.tx_pend)
        else $error("sample update missed");
    chk_divider: assert property (@(posedge clk_sys)
        disable iff (!rst_n)
        dm_en |=> state_reg.div_cnt == '0 || !state_reg.en)
        else $error("internal clock divider wrong");

endmodule : csp_port

// *** testbench/csp_host_model.sv ***
/*
 Host serial port model, frame sync loop-back framing.
 Assumes the codec pins change only just after clk_sys edges.
*/
`timescale 1ns/1ps
module csp_host_model
    import csp_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire csp_pin_out_type      pins_out,
    output logic                      rx_line,
    output logic                      rx_pulse,
    output logic                      frame_seen,
    output logic      [WORD_BITS-1:0] got_word,
    output logic                      got_valid
);
    logic [WORD_BITS-1:0] send_q[$];
    logic [WORD_BITS-1:0] sh_out;
    logic [WORD_BITS-1:0] sh_in;
    logic                 bit_in;
    logic                 sclk_prev = 1'b0;
    int                   n_out = 0;
    int                   n_in = 0;

    task automatic queue_word(input logic [WORD_BITS-1:0] w);
        send_q.push_back(w);
    endtask : queue_word

    initial begin
        rx_line    = 1'b0;
        rx_pulse   = 1'b0;
        frame_seen = 1'b0;
        got_word   = '0;
        got_valid  = 1'b0;
    end

    always @(posedge clk_sys) begin
        #1;
        frame_seen = 1'b0;
        got_valid  = 1'b0;
        if (pins_out.sclk && !sclk_prev) begin
            rx_pulse = 1'b0;
            if (n_out > 0) begin
                rx_line = sh_out[WORD_BITS-1];
                sh_out  = sh_out << 1;
                n_out   = n_out - 1;
            end else begin
                rx_line = ~rx_line;
            end
            if (pins_out.tx_frame_pulse && pins_out.tx_frame_pulse_oe) begin
                frame_seen = 1'b1;
                if (send_q.size() > 0) begin
                    sh_out   = send_q.pop_front();
                    n_out    = WORD_BITS;
                    rx_pulse = 1'b1;
                end
            end
        end
        if (!pins_out.sclk && sclk_prev) begin
            if (n_in > 0) begin
                bit_in    = pins_out.codec_tx_line_oe ?
                            pins_out.codec_tx_line : 1'bx;
                sh_in     = {sh_in[WORD_BITS-2:0], bit_in};
                n_in      = n_in - 1;
                got_word  = sh_in;
                got_valid = (n_in == 0);
            end
            if (pins_out.tx_frame_pulse) begin
                n_in = WORD_BITS;
            end
        end
        sclk_prev = pins_out.sclk;
    end
endmodule : csp_host_model

// *** testbench/tb_top.sv ***
/*
 Self-checking bench of the codec serial port with a host model.
 Assumes divider ratios as set below and loop-back framing.
*/
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
    err_count++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top
    import csp_pkg::*;
;
    localparam int MD   = 2;
    localparam int SD   = 4;
    localparam int TICK = SAMPLE_DIV * MD;
    logic                 clk_sys = 1'b0;
    logic                 rst_n;
    logic                 en;
    csp_pin_in_type       pins_in;
    csp_pin_out_type      pins_out;
    logic [WORD_BITS-1:0] adc_data;
    logic                 adc_valid;
    logic                 adc_ready;
    logic [WORD_BITS-1:0] dac_sample;
    csp_ctrl_file_type    ctrl_regs;
    logic                 rx_line;
    logic                 rx_pulse;
    logic                 frame_seen;
    logic [WORD_BITS-1:0] got_word;
    logic                 got_valid;
    logic [WORD_BITS-1:0] fifo_m[$];
    logic [WORD_BITS-1:0] exp_q[$];
    logic [WORD_BITS-1:0] last_tx;
    logic [WORD_BITS-1:0] rb_word;
    logic [CTRL_BITS-1:0] cm[CTRL_COUNT];
    bit                   rb_valid;
    bit                   tx_chk;
    int                   err_count;
    int                   n_checks;
    int                   cyc = 0;
    int                   t_prev;
    int                   t_en;
    int                   d0;

    assign pins_in = {en, rx_line, rx_pulse};

    always begin
        #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
    end

    csp_port #(.MCLK_DIV(MD), .SCLK_DIV(SD)) dut (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pins_in    (pins_in),
        .pins_out   (pins_out),
        .adc_data   (adc_data),
        .adc_valid  (adc_valid),
        .adc_ready  (adc_ready),
        .dac_sample (dac_sample),
        .ctrl_regs  (ctrl_regs)
    );

    csp_host_model host (
        .clk_sys    (clk_sys),
        .pins_out   (pins_out),
        .rx_line    (rx_line),
        .rx_pulse   (rx_pulse),
        .frame_seen (frame_seen),
        .got_word   (got_word),
        .got_valid  (got_valid)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic wait_frame;
        int                   n;
        logic [WORD_BITS-1:0] e;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (frame_seen !== 1'b1 && n < 2 * TICK);
        if (n >= 2 * TICK) begin
            err_count++;
            $display("wrong value at %0t: no frame", $time);
            end_sim;
        end
        if (t_prev != 0) begin
            `CHK(cyc - t_prev, TICK, "sample period")
        end
        t_prev = cyc;
        if (rb_valid) begin
            e        = rb_word;
            rb_valid = 1'b0;
        end else begin
            if (fifo_m.size() > 0) begin
                last_tx = fifo_m.pop_front();
            end
            e = last_tx;
        end
        if (tx_chk) begin
            exp_q.push_back(e);
        end
    endtask : wait_frame

    task automatic wait_sclk(input logic v);
        for (int n = 0; n < 64 && pins_out.sclk !== v; n++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : wait_sclk

    task automatic fill(input int n);
        bit ok;
        for (int i = 0; i < n; i++) begin
            #1;
            adc_data  = 16'($urandom);
            adc_valid = 1'b1;
            #1;
            ok = fifo_m.size() < FIFO_DEPTH;
            `CHK(adc_ready, ok, "fifo ready")
            if (ok) begin
                fifo_m.push_back(adc_data);
            end
            @(posedge clk_sys);
        end
        #1;
        adc_valid = 1'b0;
    endtask : fill

    always @(posedge clk_sys) begin
        if (got_valid === 1'b1 && tx_chk) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("wrong value at %0t: extra word", $time);
            end else begin
                `CHK(got_word, exp_q.pop_front(), "tx word")
            end
        end
    end

    initial begin
        #(40 * 60 * TICK);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim;
    end

    initial begin
        logic [CTRL_BITS-1:0] v;
        logic [WORD_BITS-1:0] w;
        logic [WORD_BITS-1:0] dprev;
        int                   t0;
        rst_n     = 1'b0;
        en        = 1'b0;
        adc_data  = '0;
        adc_valid = 1'b0;
        rb_valid  = 1'b0;
        tx_chk    = 1'b1;
        last_tx   = '0;
        err_count = 0;
        n_checks  = 0;
        t_prev    = 0;
        void'($urandom(32'h3ae9));
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        en    = 1'b1;
        t_en  = cyc;
        `CHK(ctrl_regs, '0, "ctrl reset")
        `CHK(dac_sample, WORD_RESET, "dac reset")
        `CHK(pins_out, '0, "pins reset")
        $display("test reset done");
        for (int i = 0; i <= CTRL_COUNT; i++) begin
            v = 8'($urandom);
            if (i < CTRL_COUNT) begin
                cm[i] = v;
            end
            host.queue_word({2'b10, 3'b000, 3'(i), v});
            wait_frame;
            if (i == 0) begin
                d0 = t_prev - t_en;
            end
        end
        wait_frame;
        for (int i = 0; i < CTRL_COUNT; i++) begin
            `CHK(ctrl_regs[i], cm[i], "ctrl write")
        end
        for (int i = 0; i < CTRL_COUNT; i++) begin
            host.queue_word({2'b11, 3'b000, 3'(i), 8'h00});
            wait_frame;
            rb_word  = {2'b11, 3'b000, 3'(i), cm[i]};
            rb_valid = 1'b1;
        end
        wait_frame;
        $display("test control words done");
        #1;
        wait_sclk(1'b0);
        wait_sclk(1'b1);
        t0 = cyc;
        wait_sclk(1'b0);
        wait_sclk(1'b1);
        `CHK(cyc - t0, MD * SD, "sclk period")
        for (int n = 0; n < 400 && got_valid !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        repeat (2 * MD * SD) @(posedge clk_sys);
        #1;
        `CHK(pins_out.codec_tx_line_oe, 1'b0, "idle data")
        `CHK(pins_out.tx_frame_pulse, 1'b0, "idle pulse")
        @(posedge clk_sys);
        fill(FIFO_DEPTH + 1);
        for (int i = 0; i <= FIFO_DEPTH + 1; i++) begin
            w = {1'b0, 15'($urandom)};
            host.queue_word(w);
            wait_frame;
            if (i > 0) begin
                `CHK(dac_sample, dprev, "dac word")
            end
            dprev = w;
        end
        $display("test fifo and data done");
        wait_frame;
        tx_chk = 1'b0;
        exp_q.delete();
        repeat (40) @(posedge clk_sys);
        #1;
        en = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHK(pins_out, '0, "disabled pins")
        repeat (200) @(posedge clk_sys);
        #1;
        en     = 1'b1;
        t_en   = cyc;
        t_prev = 0;
        for (int i = 0; i < CTRL_COUNT; i++) begin
            `CHK(ctrl_regs[i], cm[i], "ctrl kept")
        end
        w = {1'b0, 15'($urandom)};
        host.queue_word(w);
        wait_frame;
        `CHK((t_prev - t_en - d0) inside {-1, 0, 1}, 1'b1, "restart")
        wait_frame;
        `CHK(dac_sample, w, "dac after enable")
        $display("test port enable done");
        end_sim;
    end
endmodule : tb_top
